/* rtl/dio_map.svh */
// register offsets, field positions and reset values of the digital i/o block
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// ==========================================================
// byte offsets
`define OFS_PENDING 8'h04
`define OFS_DATA 8'h08
`define OFS_DIRECTION 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_IRQ_TYPE 8'h14
`define OFS_IRQ_POLARITY 8'h18
`define OFS_TRIGGER 8'h1C
`define OFS_HALT 8'h1E

// ==========================================================
// field positions
`define CHANNEL_FIELD_LSB 0
`define COUNTER_PENDING_LSB 16
`define TRIGGER_FIELD_LSB 0
`define HALT_FIELD_LSB 16
`define PAIR56_ODD_INDEX 4
`define PAIR78_ODD_INDEX 6

// ==========================================================
// reset values
`define RESET_DIRECTION 16'h0000
`define RESET_IRQ_MASK 16'h0000
`define RESET_IRQ_TYPE 16'h0000
`define RESET_IRQ_POLARITY 16'h0000
`define RESET_DATA_OUT 16'h0000
`define UNMAPPED_READ 32'h0000_0000

`endif

/* rtl/dio_pkg.sv */
// types shared by the digital i/o and counter command logic
package dio_pkg;

	typedef enum logic [2:0] {
		sel_none,
		sel_pending,
		sel_data,
		sel_direction,
		sel_irq_mask,
		sel_irq_type,
		sel_irq_polarity,
		sel_counter_cmd
	} reg_sel_t;

endpackage

/* rtl/input_sampler.sv */
// two-flop synchroniser for the field inputs plus a change detector
`timescale 1ns/100ps

module input_sampler #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// raw field lines
	input wire logic [WIDTH-1:0] raw_in,
	// synchronised view
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] changed
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] prev;
	logic [1:0] warm;

	// first stage is read only by the second stage
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			meta <= '0;
			level <= '0;
		end else begin
			meta <= raw_in;
			level <= meta;
		end
	end

	// successive synchronised samples are compared for edges; the compare is
	// held off until both samples are real, so a release shows no false edge
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			prev <= '0;
			changed <= '0;
			warm <= 2'h0;
		end else begin
			prev <= level;
			if (warm != 2'h3) begin
				warm <= 2'(warm + 2'h1);
			end
			changed <= (level ^ prev) & {WIDTH{warm == 2'h3}};
		end
	end

endmodule

/* rtl/pending_flags.sv */
// sticky pending flags with write-one-to-clear, set wins over clear
`timescale 1ns/100ps

module pending_flags #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// events and clears
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clear,
	// flags
	output logic [WIDTH-1:0] pending
);

	// a clear never hides an event of the same cycle
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pending <= '0;
		end else begin
			pending <= (pending & ~clear) | set;
		end
	end

endmodule

/* rtl/digital_io_interrupt_trigger.sv */
// digital i/o channels, interrupt pending register and counter command pulses
`timescale 1ns/100ps
`include "dio_map.svh"

module digital_io_interrupt_trigger
	import dio_pkg::*;
#(
	parameter int CHANNELS = 16,
	parameter int COUNTERS = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	// register port, byte address, word aligned
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [3:0] reg_byte_en,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// field i/o lines
	input wire logic [CHANNELS-1:0] dio_in,
	output logic [CHANNELS-1:0] dio_out,
	output logic [CHANNELS-1:0] dio_oe,
	// counter/timer cores
	input wire logic [COUNTERS-1:0] counter_irq_event,
	input wire logic [COUNTERS-1:0] counter_irq_enable,
	input wire logic [1:0] counter_pair_combined,
	output logic [COUNTERS-1:0] counter_trigger,
	output logic [COUNTERS-1:0] counter_halt,
	// board interrupt
	input wire logic board_irq_enable,
	output logic board_irq_pending,
	output logic irq_request
);

	// ==========================================================
	// reset and decode helpers

	logic reset_all_n;
	logic [CHANNELS-1:0] channel_level;
	logic [CHANNELS-1:0] channel_changed;
	logic [CHANNELS-1:0] channel_set;
	logic [CHANNELS-1:0] channel_clear;
	logic [CHANNELS-1:0] channel_pending;
	logic [COUNTERS-1:0] counter_set;
	logic [COUNTERS-1:0] counter_clear;
	logic [COUNTERS-1:0] counter_pending;
	logic [CHANNELS-1:0] direction;
	logic [CHANNELS-1:0] irq_mask;
	logic [CHANNELS-1:0] irq_type;
	logic [CHANNELS-1:0] irq_polarity;
	logic [31:0] write_mask;
	logic [31:0] write_bits;
	logic [31:0] pending_word;
	logic [COUNTERS-1:0] next_trigger;
	logic [COUNTERS-1:0] next_halt;
	reg_sel_t sel;

	// software reset acts exactly like power-on reset
	assign reset_all_n = reset_n & ~soft_reset;

	function automatic reg_sel_t decode(input logic [7:0] addr);
		reg_sel_t s;
		s = sel_none;
		case (addr)
			`OFS_PENDING: s = sel_pending;
			`OFS_DATA: s = sel_data;
			`OFS_DIRECTION: s = sel_direction;
			`OFS_IRQ_MASK: s = sel_irq_mask;
			`OFS_IRQ_TYPE: s = sel_irq_type;
			`OFS_IRQ_POLARITY: s = sel_irq_polarity;
			`OFS_TRIGGER: s = sel_counter_cmd;
			default: s = sel_none;
		endcase
		return s;
	endfunction

	// expand byte enables into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	// counters 1-4 sit on even bits, counters 5-8 on consecutive bits
	function automatic int counter_bit(input int idx);
		int b;
		b = (idx < 4) ? idx * 2 : idx + 4;
		return b;
	endfunction

	// ==========================================================
	// register access decode

	always_comb begin
		sel = decode(reg_addr);
		write_mask = lane_mask(reg_byte_en);
		write_bits = reg_wdata & write_mask;
	end

	// ==========================================================
	// input synchronisation

	input_sampler #(
		.WIDTH(CHANNELS)
	) u_sampler (
		.core_clk(core_clk),
		.reset_n(reset_all_n),
		.raw_in(dio_in),
		.level(channel_level),
		.changed(channel_changed)
	);

	// ==========================================================
	// configuration registers

	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			direction <= `RESET_DIRECTION;
		end else if (reg_write && sel == sel_direction) begin
			direction <= (direction & ~write_mask[15:0]) | write_bits[15:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			irq_mask <= `RESET_IRQ_MASK;
		end else if (reg_write && sel == sel_irq_mask) begin
			irq_mask <= (irq_mask & ~write_mask[15:0]) | write_bits[15:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			irq_type <= `RESET_IRQ_TYPE;
		end else if (reg_write && sel == sel_irq_type) begin
			irq_type <= (irq_type & ~write_mask[15:0]) | write_bits[15:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			irq_polarity <= `RESET_IRQ_POLARITY;
		end else if (reg_write && sel == sel_irq_polarity) begin
			irq_polarity <= (irq_polarity & ~write_mask[15:0]) | write_bits[15:0];
		end
	end

	// ==========================================================
	// output drivers

	// the output latch keeps its value while a channel is an input
	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			dio_out <= `RESET_DATA_OUT;
		end else if (reg_write && sel == sel_data) begin
			dio_out <= (dio_out & ~write_mask[15:0]) | write_bits[15:0];
		end
	end

	// the enable is the direction flop itself, with no gate in between
	always_comb begin
		dio_oe = direction;
	end

	// ==========================================================
	// channel interrupt conditions

	always_comb begin
		for (int n = 0; n < CHANNELS; n++) begin
			if (!irq_mask[n]) begin
				channel_set[n] = 1'b0;
			end else if (irq_type[n]) begin
				channel_set[n] = channel_changed[n];
			end else begin
				// a held level keeps setting the flag after each clear
				channel_set[n] = (channel_level[n] == irq_polarity[n]);
			end
		end
	end

	always_comb begin
		channel_clear = '0;
		if (reg_write && sel == sel_pending) begin
			channel_clear = write_bits[15:0];
		end
	end

	pending_flags #(
		.WIDTH(CHANNELS)
	) u_channel_pending (
		.core_clk(core_clk),
		.reset_n(reset_all_n),
		.set(channel_set),
		.clear(channel_clear),
		.pending(channel_pending)
	);

	// ==========================================================
	// counter interrupt flags

	always_comb begin
		for (int i = 0; i < COUNTERS; i++) begin
			counter_set[i] = counter_irq_event[i] & counter_irq_enable[i];
			counter_clear[i] = ~counter_irq_enable[i];
			if (reg_write && sel == sel_pending) begin
				counter_clear[i] = counter_clear[i] |
					write_bits[`COUNTER_PENDING_LSB + counter_bit(i)];
			end
		end
		// a combined pair reports through its odd counter's flag alone
		if (counter_pair_combined[0]) begin
			counter_set[`PAIR56_ODD_INDEX + 1] = 1'b0;
			counter_clear[`PAIR56_ODD_INDEX + 1] = 1'b1;
		end
		if (counter_pair_combined[1]) begin
			counter_set[`PAIR78_ODD_INDEX + 1] = 1'b0;
			counter_clear[`PAIR78_ODD_INDEX + 1] = 1'b1;
		end
	end

	pending_flags #(
		.WIDTH(COUNTERS)
	) u_counter_pending (
		.core_clk(core_clk),
		.reset_n(reset_all_n),
		.set(counter_set),
		.clear(counter_clear),
		.pending(counter_pending)
	);

	// ==========================================================
	// pending word and board request

	always_comb begin
		pending_word = '0;
		pending_word[15:0] = channel_pending;
		for (int i = 0; i < COUNTERS; i++) begin
			pending_word[`COUNTER_PENDING_LSB + counter_bit(i)] = counter_pending[i];
		end
	end

	// the board flag stands even while requests are masked off
	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			board_irq_pending <= 1'b0;
			irq_request <= 1'b0;
		end else begin
			board_irq_pending <= |pending_word;
			irq_request <= (|pending_word) & board_irq_enable;
		end
	end

	// ==========================================================
	// counter trigger and halt commands

	// a combined pair follows its odd counter's bit only
	always_comb begin
		next_trigger = '0;
		next_halt = '0;
		if (reg_write && sel == sel_counter_cmd) begin
			for (int i = 0; i < COUNTERS; i++) begin
				next_trigger[i] = write_bits[`TRIGGER_FIELD_LSB + counter_bit(i)];
				next_halt[i] = write_bits[`HALT_FIELD_LSB + counter_bit(i)];
			end
			if (counter_pair_combined[0]) begin
				next_trigger[`PAIR56_ODD_INDEX + 1] = next_trigger[`PAIR56_ODD_INDEX];
				next_halt[`PAIR56_ODD_INDEX + 1] = next_halt[`PAIR56_ODD_INDEX];
			end
			if (counter_pair_combined[1]) begin
				next_trigger[`PAIR78_ODD_INDEX + 1] = next_trigger[`PAIR78_ODD_INDEX];
				next_halt[`PAIR78_ODD_INDEX + 1] = next_halt[`PAIR78_ODD_INDEX];
			end
		end
	end

	// one register write gives exactly one pulse per addressed counter
	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			counter_trigger <= '0;
			counter_halt <= '0;
		end else begin
			counter_trigger <= next_trigger;
			counter_halt <= next_halt;
		end
	end

	// ==========================================================
	// read data

	// command bits are never stored, so that word reads zero
	always_ff @(posedge core_clk) begin
		if (!reset_all_n) begin
			reg_rdata <= `UNMAPPED_READ;
		end else if (reg_read) begin
			case (sel)
				sel_pending: reg_rdata <= pending_word;
				sel_data: reg_rdata <= {16'h0000, channel_level};
				sel_direction: reg_rdata <= {16'h0000, direction};
				sel_irq_mask: reg_rdata <= {16'h0000, irq_mask};
				sel_irq_type: reg_rdata <= {16'h0000, irq_type};
				sel_irq_polarity: reg_rdata <= {16'h0000, irq_polarity};
				sel_counter_cmd: reg_rdata <= `UNMAPPED_READ;
				default: reg_rdata <= `UNMAPPED_READ;
			endcase
		end else begin
			reg_rdata <= `UNMAPPED_READ;
		end
	end

endmodule

/* test/dio_port_chk.sv */
// port assertions for the digital i/o and counter command block
`timescale 1ns/100ps

module dio_port_chk #(
	parameter int CHANNELS = 16,
	parameter int COUNTERS = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [3:0] reg_byte_en,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// field lines and counters
	input wire logic [CHANNELS-1:0] dio_oe,
	input wire logic [1:0] counter_pair_combined,
	input wire logic [COUNTERS-1:0] counter_trigger,
	input wire logic [COUNTERS-1:0] counter_halt,
	// board interrupt
	input wire logic board_irq_enable,
	input wire logic board_irq_pending,
	input wire logic irq_request
);
	// ==========================================
	// command word decode
	logic cmd_wr;
	assign cmd_wr = reg_write && reg_addr == 8'h1C;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n || soft_reset);

	// ==========================================
	// properties
	a_cmd_reads_zero: assert property (reg_read && reg_addr == 8'h1C
		|=> reg_rdata == 32'h0)
		else $error("command word read not zero");
	a_data_upper_zero: assert property (reg_read && reg_addr == 8'h08
		|=> reg_rdata[31:16] == 16'h0)
		else $error("data upper half not zero");
	a_trig_first: assert property (cmd_wr && reg_byte_en[0] && reg_wdata[0]
		|=> counter_trigger[0])
		else $error("counter 1 trigger missing");
	a_trig_pair: assert property (cmd_wr && reg_byte_en[1] && reg_wdata[10]
		&& counter_pair_combined[1] |=> counter_trigger[7:6] == 2'b11)
		else $error("combined pair trigger missing");
	a_halt_second: assert property (cmd_wr && reg_byte_en[2] && reg_wdata[18]
		|=> counter_halt[1])
		else $error("counter 2 halt missing");
	a_halt_pair: assert property (cmd_wr && reg_byte_en[3] && reg_wdata[24]
		&& counter_pair_combined[0] |=> counter_halt[5:4] == 2'b11)
		else $error("combined pair halt missing");
	a_cmd_one_pulse: assert property (!cmd_wr
		|=> counter_trigger == '0 && counter_halt == '0)
		else $error("command pulse without write");
	a_unused_quiet: assert property (cmd_wr && reg_byte_en == 4'hF
		&& reg_wdata == 32'hF0AA_F0AA |=> counter_trigger == '0 && counter_halt == '0)
		else $error("unused command bit acted");
	a_irq_gate_enable: assert property (irq_request
		|-> $past(board_irq_enable) && board_irq_pending)
		else $error("request without enable or pending");
	a_reset_inputs: assert property ($rose(reset_n) |-> dio_oe == '0)
		else $error("channel driven after reset");
	c_trigger: cover property (counter_trigger[0]);
	c_halt_pair: cover property (counter_halt[5:4] == 2'b11);
	c_request: cover property (irq_request);
endmodule

/* test/dio_field_model.sv */
// field lines and counter cores seen from the far side of the block
`timescale 1ns/100ps

module dio_field_model (
	// clock
	input wire logic core_clk,
	// field lines
	input wire logic [15:0] field_level,
	input wire logic [15:0] dio_out,
	input wire logic [15:0] dio_oe,
	output logic [15:0] dio_in,
	// counter cores
	input wire logic [7:0] counter_trigger,
	input wire logic [7:0] counter_halt,
	output logic [7:0] counter_irq_event,
	output logic [7:0] running
);
	// ==========================================
	// pin level: the block's latch where it drives, the field elsewhere
	assign dio_in = (dio_oe & dio_out) | (~dio_oe & field_level);
	initial counter_irq_event = 8'h00;
	initial running = 8'h00;
	// a started core raises one event at once; a stopped core goes idle
	always @(posedge core_clk) begin
		counter_irq_event <= counter_trigger;
		running <= (running | counter_trigger) & ~counter_halt;
	end
endmodule

/* test/digital_io_interrupt_trigger_bench.sv */
// self-checking bench for the digital i/o and counter command block
`timescale 1ns/100ps

module digital_io_interrupt_trigger_bench;
	logic core_clk = 1'b0;
	logic reset_n, soft_reset, reg_write, reg_read, board_irq_enable;
	logic board_irq_pending, irq_request;
	logic [7:0] reg_addr, counter_irq_event, counter_irq_enable, counter_trigger, counter_halt;
	logic [7:0] running;
	logic [3:0] reg_byte_en;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] dio_in, dio_out, dio_oe, field;
	logic [1:0] counter_pair_combined;
	int num_errors = 0;
	int n_tests = 0;

	always #2.5 core_clk = ~core_clk;

	digital_io_interrupt_trigger dut (.core_clk(core_clk), .reset_n(reset_n),
		.soft_reset(soft_reset), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_read(reg_read), .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
		.counter_irq_event(counter_irq_event), .counter_irq_enable(counter_irq_enable),
		.counter_pair_combined(counter_pair_combined), .counter_trigger(counter_trigger),
		.counter_halt(counter_halt), .board_irq_enable(board_irq_enable),
		.board_irq_pending(board_irq_pending), .irq_request(irq_request));

	dio_field_model far (.core_clk(core_clk), .field_level(field), .dio_out(dio_out),
		.dio_oe(dio_oe), .dio_in(dio_in), .counter_trigger(counter_trigger),
		.counter_halt(counter_halt), .counter_irq_event(counter_irq_event), .running(running));

	// ==========================================
	// access tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_byte_en = be;
		reg_write = 1'b1;
		@(negedge core_clk);
		reg_write = 1'b0;
	endtask

	// read data stands for the one cycle after the taking edge
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge core_clk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge core_clk);
		reg_read = 1'b0;
		chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================
	// tests
	initial begin
		{reset_n, soft_reset, reg_write, reg_read, board_irq_enable} = 5'h00;
		{reg_addr, reg_byte_en, reg_wdata, counter_irq_enable, counter_pair_combined} = '0;
		field = 16'hFFFF;
		repeat (12) @(negedge core_clk);
		reset_n = 1'b1;
		rd(8'h0C, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h00, 32'h0);
		wr(8'h0C, 32'hFFFF_00FF, 4'hF);
		wr(8'h08, 32'h0000_1234, 4'hF);
		repeat (3) @(negedge core_clk);
		rd(8'h08, 32'h0000_FF34);
		rd(8'h0C, 32'h0000_00FF);
		chk("dio_oe", 32'h00FF, {16'h0, dio_oe});
		wr(8'h0C, 32'h0, 4'hF);
		// ch0 low level, ch1 masked, ch2 high level, ch3 change with polarity set
		field = 16'hFFFC;
		wr(8'h18, 32'h0000_000C, 4'hF);
		wr(8'h14, 32'h0000_0008, 4'hF);
		wr(8'h10, 32'h0000_000D, 4'hF);
		repeat (6) @(negedge core_clk);
		rd(8'h04, 32'h0000_0005);
		wr(8'h04, 32'h0, 4'hF);
		rd(8'h04, 32'h0000_0005);
		field = 16'hFFFD;
		repeat (5) @(negedge core_clk);
		wr(8'h04, 32'h0000_0001, 4'hF);
		rd(8'h04, 32'h0000_0004);
		wr(8'h04, 32'h0000_0004, 4'hF);
		rd(8'h04, 32'h0000_0004);
		field = 16'hFFF5;
		repeat (6) @(negedge core_clk);
		rd(8'h04, 32'h0000_000C);
		wr(8'h04, 32'h0, 4'hF);
		rd(8'h04, 32'h0000_000C);
		wr(8'h04, 32'h0000_0008, 4'hF);
		rd(8'h04, 32'h0000_0004);
		field = 16'hFFFD;
		repeat (6) @(negedge core_clk);
		rd(8'h04, 32'h0000_000C);
		chk("irq_request", 32'h0, {31'h0, irq_request});
		chk("board_irq_pending", 32'h1, {31'h0, board_irq_pending});
		board_irq_enable = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("irq_request", 32'h1, {31'h0, irq_request});
		field = 16'hFFF9;
		repeat (5) @(negedge core_clk);
		wr(8'h04, 32'hFFFF_FFFF, 4'hF);
		repeat (3) @(negedge core_clk);
		chk("irq_request", 32'h0, {31'h0, irq_request});
		rd(8'h04, 32'h0);
		// counters: pair 5+6 combined, only counters 1 and 5 enabled
		counter_irq_enable = 8'h11;
		counter_pair_combined = 2'b01;
		wr(8'h1C, 32'h0000_0101, 4'h3);
		@(negedge core_clk);
		chk("running", 32'h31, {24'h0, running});
		rd(8'h04, 32'h0101_0000);
		counter_irq_enable = 8'h01;
		repeat (2) @(negedge core_clk);
		rd(8'h04, 32'h0001_0000);
		wr(8'h04, 32'h0001_0000, 4'hF);
		rd(8'h04, 32'h0);
		wr(8'h1C, 32'h0500_0000, 4'hC);
		@(negedge core_clk);
		chk("running", 32'h01, {24'h0, running});
		counter_pair_combined = 2'b10;
		wr(8'h1C, 32'h0005_0400, 4'hF);
		@(negedge core_clk);
		chk("running", 32'hC0, {24'h0, running});
		counter_pair_combined = 2'b00;
		wr(8'h1C, 32'hF0AA_F0AA, 4'hF);
		@(negedge core_clk);
		chk("running", 32'hC0, {24'h0, running});
		rd(8'h1C, 32'h0);
		// software reset returns channels to inputs with masks cleared
		wr(8'h10, 32'h0000_FFFF, 4'hF);
		wr(8'h0C, 32'h0000_00FF, 4'hF);
		soft_reset = 1'b1;
		@(negedge core_clk);
		soft_reset = 1'b0;
		rd(8'h0C, 32'h0);
		rd(8'h10, 32'h0);
		chk("dio_oe", 32'h0, {16'h0, dio_oe});
		results();
	end

	// the sequence needs well under a thousand cycles
	initial begin
		#20000;
		num_errors++;
		results();
	end
endmodule

bind digital_io_interrupt_trigger dio_port_chk #(.CHANNELS(CHANNELS), .COUNTERS(COUNTERS)) chk_i (
	.core_clk(core_clk), .reset_n(reset_n), .soft_reset(soft_reset), .reg_addr(reg_addr),
	.reg_write(reg_write), .reg_read(reg_read), .reg_byte_en(reg_byte_en),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dio_oe(dio_oe),
	.counter_pair_combined(counter_pair_combined), .counter_trigger(counter_trigger),
	.counter_halt(counter_halt), .board_irq_enable(board_irq_enable),
	.board_irq_pending(board_irq_pending), .irq_request(irq_request));
